//--- design/core_pkg.sv
package core_pkg;
  // ---------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------
  localparam int PC_W        = 9;
  localparam int NUM_GPR     = 32;
  localparam int IO_ADDR_W   = 6;
  localparam int STACK_DEPTH = 3;

  // ---------------------------------------------------------------
  // I/O map
  // ---------------------------------------------------------------
  localparam logic [5:0] STATUS_FLAGS_ADDR = 6'h3F;
  localparam logic [5:0] BIT_IO_LAST       = 6'h1F;
  localparam logic [7:0] STATUS_FLAGS_RST  = 8'h00;

  // ---------------------------------------------------------------
  // Status flag positions
  // ---------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ---------------------------------------------------------------
  // Register pointer and immediate bank
  // ---------------------------------------------------------------
  localparam logic [4:0] POINTER_REG_THIRTY = 5'h1E;
  localparam logic [4:0] IMM_BANK_BASE      = 5'h10;
  localparam logic [PC_W-1:0] RESET_VECTOR  = 9'h000;

  // ---------------------------------------------------------------
  // Instruction fields
  // ---------------------------------------------------------------
  localparam int DISP_W = 12;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR,
    OP_MOV, OP_COM, OP_NEG, OP_INC, OP_DEC, OP_LSR, OP_ROR,
    OP_SUBI, OP_ANDI, OP_ORI, OP_LDI, OP_LD_IND, OP_ST_IND,
    OP_IO_LOAD, OP_IO_STORE, OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_SKIP_BIT_ONE, OP_SKIP_BIT_ZERO, OP_REL_JUMP, OP_REL_CALL,
    OP_SUB_EXIT, OP_INT_EXIT, OP_COPY_BIT
  } opcode_t;
endpackage

//--- design/gpr_file.sv
`timescale 1ns/1ps
module gpr_file
  import core_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [4:0] rd_addr_a,
  input  wire logic [4:0] rd_addr_b,
  output logic      [7:0] rd_data_a,
  output logic      [7:0] rd_data_b,
  input  wire logic       wr_en,
  input  wire logic [4:0] wr_addr,
  input  wire logic [7:0] wr_data
);
  // Asynchronous read ports so both operands, the ALU and write-back
  // fit in one cycle; registered read would cost a pipeline stage.
  logic [7:0] mem [NUM_GPR];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data_a = mem[rd_addr_a];
  assign rd_data_b = mem[rd_addr_b];
endmodule

//--- design/cpu_addressing_stack_status.sv
`timescale 1ns/1ps
// Operation
// - Single-register ops take their operand from the destination register.
// - Indirect ops access the register indexed by register 30.
// - Two-register ops read source and destination, result to destination.
// - I/O address comes from a 6-bit instruction field.
// - Relative jump and call go to program counter plus signed offset.
// - Return stack is 3 levels of 9-bit addresses.
// - Call or interrupt pushes to level 0, older levels move deeper.
// - Returns pop level 0 into program counter, levels shift up.
// - Calls beyond depth 3 silently drop the oldest address.
// - Core runs straight from the system clock, no divider.
// - Register read, ALU and write-back finish in one cycle.
// - io_load and io_store move data between registers and I/O.
// - Bit set and clear only act on I/O addresses 00 to 1F.
// - Skip-on-bit instructions test I/O bits in the same range.
// - Flag bit 7 is global interrupt enable, gating all interrupts.
// - Taking an interrupt clears enable; interrupt_exit sets it again.
// - Flag bit 6 is the copy bit for store and load copy-bit.
// - Sign flag always equals negative xor overflow.
// - Zero flag on zero result, negative flag on negative result.
// - Carry flag holds the operation carry.
// - Overflow flag holds two's complement overflow.
// - Half carry holds the carry out of the low nibble.
// - Immediate instructions address only registers 16 to 31.
// - Program counter is 9 bits and relative targets wrap.
module cpu_addressing_stack_status
  import core_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             instr_valid,
  input  wire opcode_t          instr_op,
  input  wire logic [4:0]       dest_sel,
  input  wire logic [4:0]       src_sel,
  input  wire logic [7:0]       imm_value,
  input  wire logic [5:0]       io_addr,
  input  wire logic [2:0]       bit_sel,
  input  wire logic             copy_dir_load,
  input  wire logic [DISP_W-1:0] rel_disp,
  input  wire logic             irq_pending,
  input  wire logic [PC_W-1:0]  irq_vector,
  input  wire logic [7:0]       io_rd_data,
  input  wire logic             io_rd_mapped,
  output logic [PC_W-1:0]       program_counter,
  output logic                  skip_next,
  output logic                  irq_taken,
  output logic [5:0]            io_addr_out,
  output logic [7:0]            io_wr_data,
  output logic                  io_wr_en,
  output logic [7:0]            status_flags_register,
  output logic [1:0]            stack_fill
);
  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [PC_W-1:0]             pc;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [1:0]                  fill;
    logic [7:0]                  status_flags;
    logic                        skip;
    logic                        irq_ack;
    logic [5:0]                  io_a;
    logic [7:0]                  io_d;
    logic                        io_we;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [PC_W-1:0] rel_target(
    input logic [PC_W-1:0] pc, input logic [DISP_W-1:0] k);
    // Only the low bits matter because the address space wraps
    rel_target = pc + k[PC_W-1:0];
  endfunction

  function automatic logic [7:0] flags_update(
    input logic [7:0] old, input logic [7:0] res, input logic c,
    input logic v, input logic h, input logic upd_chv);
    logic [7:0] f;
    f = old;
    f[FLAG_Z] = (res == 8'h00);
    f[FLAG_N] = res[7];
    if (upd_chv) begin
      f[FLAG_C] = c;
      f[FLAG_H] = h;
    end
    f[FLAG_V] = v;
    f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
    flags_update = f;
  endfunction

  // -----------------------------------------------------------------
  // Register file
  // -----------------------------------------------------------------
  logic [4:0] ra_addr;
  logic [4:0] rb_addr;
  logic [7:0] ra_data;
  logic [7:0] rb_data;
  logic [7:0] ptr_data;
  logic       gpr_we;
  logic [4:0] gpr_wa;
  logic [7:0] gpr_wd;
  logic [4:0] dest_eff;

  // Immediate forms only reach the upper bank
  assign dest_eff = (instr_op inside {OP_SUBI, OP_ANDI, OP_ORI, OP_LDI})
                    ? (dest_sel | IMM_BANK_BASE) : dest_sel;

  // Port B doubles as pointer read for indirect forms
  assign rb_addr  = (instr_op inside {OP_LD_IND, OP_ST_IND})
                    ? POINTER_REG_THIRTY : src_sel;
  assign ptr_data = rb_data;
  assign ra_addr  = (instr_op == OP_ST_IND) ? dest_sel : dest_eff;

  // Indirect load needs a third read; reuse port A by redirecting
  logic [7:0] ind_data;
  logic [4:0] ind_addr;
  assign ind_addr = ptr_data[4:0];

  gpr_file u_gpr (
    .ref_clk   (ref_clk),
    .rd_addr_a ((instr_op == OP_LD_IND) ? ind_addr : ra_addr),
    .rd_addr_b (rb_addr),
    .rd_data_a (ra_data),
    .rd_data_b (rb_data),
    .wr_en     (gpr_we),
    .wr_addr   (gpr_wa),
    .wr_data   (gpr_wd)
  );
  assign ind_data = ra_data;

  // -----------------------------------------------------------------
  // Next state and ALU, all settled within the cycle
  // -----------------------------------------------------------------
  always_comb begin
    logic [8:0] sum;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [7:0] res;
    logic       h;
    logic       v;
    logic       io_ok;
    logic [7:0] io_val;
    sum = 9'h000;
    opa = ra_data;
    opb = rb_data;
    res = 8'h00;
    h = 1'b0;
    v = 1'b0;
    st_next = st_reg;
    st_next.irq_ack = 1'b0;
    st_next.io_we = 1'b0;
    gpr_we = 1'b0;
    gpr_wa = dest_eff;
    gpr_wd = 8'h00;
    io_ok = io_rd_mapped;
    // Reserved locations read as zero
    io_val = (io_addr == STATUS_FLAGS_ADDR) ? st_reg.status_flags
             : (io_ok ? io_rd_data : 8'h00);

    if (irq_pending && st_reg.status_flags[FLAG_I] && !st_reg.skip) begin
      // Interrupt entry replaces the instruction in this slot
      st_next.stack = {st_reg.stack[1:0], st_reg.pc};
      if (st_reg.fill != 2'(STACK_DEPTH)) begin
        st_next.fill = st_reg.fill + 2'd1;
      end
      st_next.pc = irq_vector;
      st_next.status_flags[FLAG_I] = 1'b0;
      st_next.irq_ack = 1'b1;
    end else if (instr_valid) begin
      // Skip holds over idle cycles until an instruction consumes it
      st_next.skip = 1'b0;
      st_next.pc = st_reg.pc + 9'd1;
      if (st_reg.skip) begin
        // Skipped instruction only advances the counter
      end else begin
        unique case (instr_op)
          OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_SUBI: begin
            if (instr_op == OP_SUBI) opb = imm_value;
            if (instr_op inside {OP_ADD, OP_ADC}) begin
              sum = {1'b0, opa} + {1'b0, opb}
                    + {8'h00, instr_op == OP_ADC && st_reg.status_flags[FLAG_C]};
              h = (opa[3] & opb[3]) | (opb[3] & ~sum[3]) | (~sum[3] & opa[3]);
              v = (opa[7] == opb[7]) && (sum[7] != opa[7]);
            end else begin
              sum = {1'b0, opa} - {1'b0, opb}
                    - {8'h00, instr_op == OP_SBC && st_reg.status_flags[FLAG_C]};
              h = (~opa[3] & opb[3]) | (opb[3] & sum[3]) | (sum[3] & ~opa[3]);
              v = (opa[7] != opb[7]) && (sum[7] != opa[7]);
            end
            res = sum[7:0];
            st_next.status_flags = flags_update(st_reg.status_flags, res, sum[8], v, h, 1'b1);
            gpr_we = 1'b1;
            gpr_wd = res;
          end
          OP_AND, OP_OR, OP_EOR, OP_ANDI, OP_ORI: begin
            if (instr_op inside {OP_ANDI, OP_ORI}) opb = imm_value;
            unique case (instr_op)
              OP_AND, OP_ANDI: res = opa & opb;
              OP_OR, OP_ORI:   res = opa | opb;
              default:         res = opa ^ opb;
            endcase
            st_next.status_flags = flags_update(st_reg.status_flags, res, 1'b0, 1'b0,
                                        1'b0, 1'b0);
            gpr_we = 1'b1;
            gpr_wd = res;
          end
          OP_MOV: begin
            gpr_we = 1'b1;
            gpr_wd = opb;
          end
          OP_LDI: begin
            gpr_we = 1'b1;
            gpr_wd = imm_value;
          end
          OP_COM, OP_NEG, OP_INC, OP_DEC, OP_LSR, OP_ROR: begin
            unique case (instr_op)
              OP_COM: begin
                res = ~opa;
                sum = {1'b1, res};
              end
              OP_NEG: begin
                sum = 9'h000 - {1'b0, opa};
                res = sum[7:0];
                v = (res == 8'h80);
                h = res[3] | opa[3];
              end
              OP_INC: begin
                res = opa + 8'h01;
                v = (res == 8'h80);
                sum = {st_reg.status_flags[FLAG_C], res};
              end
              OP_DEC: begin
                res = opa - 8'h01;
                v = (res == 8'h7F);
                sum = {st_reg.status_flags[FLAG_C], res};
              end
              default: begin
                res = {(instr_op == OP_ROR) & st_reg.status_flags[FLAG_C], opa[7:1]};
                sum = {opa[0], res};
                v = res[7] ^ opa[0];
              end
            endcase
            st_next.status_flags = flags_update(st_reg.status_flags, res, sum[8], v, h,
                                        1'b1);
            if (instr_op inside {OP_INC, OP_DEC, OP_LSR, OP_ROR, OP_COM})
              st_next.status_flags[FLAG_H] = st_reg.status_flags[FLAG_H];
            gpr_we = 1'b1;
            gpr_wd = res;
          end
          OP_LD_IND: begin
            gpr_wa = dest_sel;
            gpr_we = 1'b1;
            gpr_wd = ind_data;
          end
          OP_ST_IND: begin
            gpr_wa = ptr_data[4:0];
            gpr_we = 1'b1;
            gpr_wd = ra_data;
          end
          OP_IO_LOAD: begin
            gpr_we = 1'b1;
            gpr_wd = io_val;
          end
          OP_IO_STORE: begin
            st_next.io_a = io_addr;
            if (io_addr == STATUS_FLAGS_ADDR) begin
              st_next.status_flags = ra_data;
              st_next.status_flags[FLAG_S] = ra_data[FLAG_N] ^ ra_data[FLAG_V];
            end else if (io_ok) begin
              st_next.io_d = ra_data;
              st_next.io_we = 1'b1;
            end
          end
          OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
            if (io_addr <= BIT_IO_LAST && io_ok) begin
              st_next.io_a = io_addr;
              st_next.io_d = io_rd_data;
              st_next.io_d[bit_sel] = (instr_op == OP_IO_BIT_SET);
              st_next.io_we = 1'b1;
            end
          end
          OP_SKIP_BIT_ONE, OP_SKIP_BIT_ZERO: begin
            if (io_addr <= BIT_IO_LAST) begin
              st_next.skip = io_val[bit_sel]
                             == (instr_op == OP_SKIP_BIT_ONE);
            end
          end
          OP_REL_JUMP: begin
            st_next.pc = rel_target(st_reg.pc, rel_disp);
          end
          OP_REL_CALL: begin
            st_next.stack = {st_reg.stack[1:0], st_next.pc};
            if (st_reg.fill != 2'(STACK_DEPTH)) begin
              st_next.fill = st_reg.fill + 2'd1;
            end
            st_next.pc = rel_target(st_reg.pc, rel_disp);
          end
          OP_SUB_EXIT, OP_INT_EXIT: begin
            st_next.pc = st_reg.stack[0];
            st_next.stack = {st_reg.stack[2], st_reg.stack[2:1]};
            if (st_reg.fill != 2'd0) begin
              st_next.fill = st_reg.fill - 2'd1;
            end
            if (instr_op == OP_INT_EXIT) begin
              st_next.status_flags[FLAG_I] = 1'b1;
            end
          end
          OP_COPY_BIT: begin
            if (copy_dir_load) begin
              gpr_we = 1'b1;
              gpr_wd = opa;
              gpr_wd[bit_sel] = st_reg.status_flags[FLAG_T];
            end else begin
              st_next.status_flags[FLAG_T] = opa[bit_sel];
            end
          end
          OP_NOP: begin
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.pc <= RESET_VECTOR;
      st_reg.status_flags <= STATUS_FLAGS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign program_counter       = st_reg.pc;
  assign skip_next             = st_reg.skip;
  assign irq_taken             = st_reg.irq_ack;
  assign io_addr_out           = st_reg.io_a;
  assign io_wr_data            = st_reg.io_d;
  assign io_wr_en              = st_reg.io_we;
  assign status_flags_register = st_reg.status_flags;
  assign stack_fill            = st_reg.fill;
endmodule

//--- tb/periph_model.sv
`timescale 1ns/1ps
module periph_model
  import core_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [5:0] io_addr,
  input  wire logic [5:0] io_addr_out,
  input  wire logic [7:0] io_wr_data,
  input  wire logic       io_wr_en,
  output logic      [7:0] io_rd_data,
  output logic            io_rd_mapped
);
  // ---------------------------------------------------------------
  // Peripheral register space
  // ---------------------------------------------------------------
  // Implemented locations; 3F lives inside the core, not here
  localparam logic [63:0] MAP = 64'h0B2C_0002_71C7_0100;
  logic [7:0] mem [64];

  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'hC3;
  end

  always @(posedge ref_clk) begin
    if (io_wr_en && MAP[io_addr_out]) mem[io_addr_out] <= io_wr_data;
  end

  // Unmapped places show junk, so a core that does not mask them is seen
  assign io_rd_mapped = MAP[io_addr];
  assign io_rd_data   = MAP[io_addr] ? mem[io_addr] : ~mem[io_addr];
endmodule

//--- tb/core_props.sv
`timescale 1ns/1ps
module core_props
  import core_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic              instr_valid,
  input wire opcode_t           instr_op,
  input wire logic [5:0]        io_addr,
  input wire logic [2:0]        bit_sel,
  input wire logic [DISP_W-1:0] rel_disp,
  input wire logic              irq_pending,
  input wire logic [PC_W-1:0]   irq_vector,
  input wire logic [7:0]        io_rd_data,
  input wire logic              io_rd_mapped,
  input wire logic [PC_W-1:0]   program_counter,
  input wire logic              skip_next,
  input wire logic              irq_taken,
  input wire logic              io_wr_en,
  input wire logic [7:0]        status_flags_register,
  input wire logic [1:0]        stack_fill
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic irq_go;
  logic run;
  logic bit_now;
  logic [8:0] disp9;
  assign irq_go  = irq_pending && status_flags_register[7] && !skip_next;
  assign run     = instr_valid && !irq_go && !skip_next;
  assign bit_now = io_rd_mapped && io_rd_data[bit_sel];
  assign disp9   = rel_disp[8:0];

  sequence s_irq_done;
    irq_taken && !status_flags_register[7] ##1 !irq_taken;
  endsequence

  a_pc_step: assert property (run && !(instr_op inside {OP_REL_JUMP,
    OP_REL_CALL, OP_SUB_EXIT, OP_INT_EXIT}) |=>
    program_counter == $past(program_counter) + 9'h001)
    else $error("pc did not step by one");
  a_rel_target: assert property (run && instr_op == OP_REL_JUMP |=>
    program_counter == $past(program_counter) + $past(disp9))
    else $error("relative jump target wrong");
  a_call_push: assert property (run && instr_op == OP_REL_CALL &&
    stack_fill != 2'h3 |=> stack_fill == $past(stack_fill) + 2'h1)
    else $error("call did not deepen stack");
  a_call_sat: assert property (run && instr_op == OP_REL_CALL &&
    stack_fill == 2'h3 |=> stack_fill == 2'h3)
    else $error("full stack count changed");
  a_irq_gate: assert property (!status_flags_register[7] |=>
    !irq_taken)
    else $error("interrupt taken while disabled");
  a_irq_entry: assert property (irq_go |=> s_irq_done)
    else $error("interrupt entry pulse or enable wrong");
  a_irq_vector: assert property (irq_go |=>
    program_counter == $past(irq_vector) && stack_fill != 2'h0)
    else $error("interrupt did not vector");
  a_exit_enable: assert property (run && instr_op == OP_INT_EXIT |=>
    status_flags_register[7])
    else $error("interrupt exit left enable low");
  a_sign_flag: assert property (status_flags_register[4] ==
    (status_flags_register[2] ^ status_flags_register[3]))
    else $error("sign flag not n xor v");
  a_bit_range: assert property (run && (instr_op inside {OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR}) && io_addr > BIT_IO_LAST |=> !io_wr_en)
    else $error("bit write above bit range");
  a_skip_test: assert property (run && instr_op == OP_SKIP_BIT_ONE &&
    io_addr <= BIT_IO_LAST |=> skip_next == $past(bit_now))
    else $error("skip decision wrong");
  a_skip_out: assert property (skip_next && instr_valid |=>
    program_counter == $past(program_counter) + 9'h001 && !skip_next)
    else $error("skipped instruction misbehaved");
endmodule

bind cpu_addressing_stack_status core_props u_props (
  .ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
  .instr_op(instr_op), .io_addr(io_addr), .bit_sel(bit_sel),
  .rel_disp(rel_disp), .irq_pending(irq_pending),
  .irq_vector(irq_vector), .io_rd_data(io_rd_data),
  .io_rd_mapped(io_rd_mapped), .program_counter(program_counter),
  .skip_next(skip_next), .irq_taken(irq_taken), .io_wr_en(io_wr_en),
  .status_flags_register(status_flags_register),
  .stack_fill(stack_fill));

//--- tb/tb.sv
`timescale 1ns/1ps
module tb
  import core_pkg::*;
;
  logic ref_clk, rst, instr_valid, copy_dir_load, irq_pending;
  opcode_t instr_op;
  logic [4:0] dest_sel, src_sel;
  logic [7:0] imm_value, io_rd_data, io_wr_data, status_flags_register;
  logic [5:0] io_addr, io_addr_out;
  logic [2:0] bit_sel;
  logic [11:0] rel_disp;
  logic [8:0] irq_vector, program_counter;
  logic [1:0] stack_fill;
  logic io_rd_mapped, skip_next, irq_taken, io_wr_en;
  logic wr_seen;
  logic [5:0] wr_addr;
  logic [7:0] wr_dat;
  int bad_count = 0;
  int n_compared = 0;

  cpu_addressing_stack_status dut (.ref_clk(ref_clk), .rst(rst),
    .instr_valid(instr_valid), .instr_op(instr_op), .dest_sel(dest_sel),
    .src_sel(src_sel), .imm_value(imm_value), .io_addr(io_addr),
    .bit_sel(bit_sel), .copy_dir_load(copy_dir_load), .rel_disp(rel_disp),
    .irq_pending(irq_pending), .irq_vector(irq_vector),
    .io_rd_data(io_rd_data), .io_rd_mapped(io_rd_mapped),
    .program_counter(program_counter), .skip_next(skip_next),
    .irq_taken(irq_taken), .io_addr_out(io_addr_out),
    .io_wr_data(io_wr_data), .io_wr_en(io_wr_en),
    .status_flags_register(status_flags_register),
    .stack_fill(stack_fill));
  periph_model u_periph (.ref_clk(ref_clk), .io_addr(io_addr),
    .io_addr_out(io_addr_out), .io_wr_data(io_wr_data),
    .io_wr_en(io_wr_en), .io_rd_data(io_rd_data),
    .io_rd_mapped(io_rd_mapped));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [8:0] g, input logic [8:0] e,
                     input string m);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask

  // One instruction, then an idle cycle; the write pulse is caught
  task automatic ex(input opcode_t o, input logic [4:0] d, s,
    input logic [7:0] k, input logic [5:0] a, input logic [2:0] b,
    input logic [11:0] r);
    instr_op = o; dest_sel = d; src_sel = s; imm_value = k;
    io_addr = a; bit_sel = b; rel_disp = r; instr_valid = 1'b1;
    @(negedge ref_clk);
    wr_seen = io_wr_en; wr_addr = io_addr_out; wr_dat = io_wr_data;
    instr_valid = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic ldi(input logic [4:0] d, input logic [7:0] k);
    ex(OP_LDI, d, d, k, 6'h00, 3'h0, 12'h000);
  endtask

  // Source and destination equal, so either field selects the register
  task automatic stc(input logic [4:0] d, input logic [5:0] a,
                     input logic [7:0] e);
    ex(OP_IO_STORE, d, d, 8'h00, a, 3'h0, 12'h000);
    chk(wr_seen, 1'b1, "store pulse");
    chk(wr_addr, a, "store address");
    chk(wr_dat, e, "store data");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_alu;
    logic [8:0] p;
    ldi(5'h00, 8'h7F);
    ldi(5'h11, 8'h01);
    p = program_counter;
    ex(OP_ADD, 5'h10, 5'h11, 8'h00, 6'h00, 3'h0, 12'h000);
    chk(program_counter, p + 9'h001, "add pc");
    chk(status_flags_register, 8'h2C, "add flags");
    stc(5'h10, 6'h18, 8'h80);
    ldi(5'h12, 8'hFF);
    ex(OP_ADD, 5'h12, 5'h11, 8'h00, 6'h00, 3'h0, 12'h000);
    chk(status_flags_register, 8'h23, "carry flags");
    ex(OP_SUB, 5'h11, 5'h11, 8'h00, 6'h00, 3'h0, 12'h000);
    chk(status_flags_register, 8'h02, "zero flags");
    ldi(5'h1E, 8'h10);
    ex(OP_LD_IND, 5'h01, 5'h01, 8'h00, 6'h00, 3'h0, 12'h000);
    stc(5'h01, 6'h11, 8'h80);
    copy_dir_load = 1'b0;
    ldi(5'h10, 8'h04);
    ex(OP_COPY_BIT, 5'h10, 5'h10, 8'h00, 6'h00, 3'h2, 12'h000);
    chk(status_flags_register[6], 1'b1, "copy bit store");
    copy_dir_load = 1'b1;
    ldi(5'h13, 8'h00);
    ex(OP_COPY_BIT, 5'h13, 5'h13, 8'h00, 6'h00, 3'h7, 12'h000);
    stc(5'h13, 6'h12, 8'h80);
    ex(OP_SUBI, 5'h03, 5'h03, 8'h01, 6'h00, 3'h0, 12'h000);
    stc(5'h13, 6'h12, 8'h7F);
    copy_dir_load = 1'b0;
    $display("alu and copy test done");
  endtask

  task automatic t_io;
    logic [8:0] p;
    ex(OP_IO_LOAD, 5'h03, 5'h03, 8'h00, 6'h32, 3'h0, 12'h000);
    stc(5'h03, 6'h12, 8'hF1);
    ex(OP_IO_LOAD, 5'h02, 5'h02, 8'h00, 6'h20, 3'h0, 12'h000);
    stc(5'h02, 6'h12, 8'h00);
    ex(OP_IO_BIT_SET, 5'h00, 5'h00, 8'h00, 6'h16, 3'h1, 12'h000);
    chk(wr_dat, 8'hD7, "bit set");
    ex(OP_IO_BIT_CLEAR, 5'h00, 5'h00, 8'h00, 6'h16, 3'h0, 12'h000);
    chk(wr_dat, 8'hD6, "bit clear");
    ex(OP_IO_BIT_SET, 5'h00, 5'h00, 8'h00, 6'h20, 3'h0, 12'h000);
    chk(wr_seen, 1'b0, "bit set out of range");
    ex(OP_SKIP_BIT_ONE, 5'h00, 5'h00, 8'h00, 6'h16, 3'h1, 12'h000);
    chk(skip_next, 1'b1, "skip on one");
    p = program_counter;
    ldi(5'h10, 8'hEE);
    chk(program_counter, p + 9'h001, "skipped pc");
    stc(5'h10, 6'h12, 8'h04);
    ex(OP_SKIP_BIT_ZERO, 5'h00, 5'h00, 8'h00, 6'h16, 3'h1, 12'h000);
    chk(skip_next, 1'b0, "no skip on zero");
    ex(OP_SKIP_BIT_ZERO, 5'h00, 5'h00, 8'h00, 6'h16, 3'h0, 12'h000);
    chk(skip_next, 1'b1, "skip on zero");
    ex(OP_NOP, 5'h00, 5'h00, 8'h00, 6'h00, 3'h0, 12'h000);
    ex(OP_SKIP_BIT_ONE, 5'h00, 5'h00, 8'h00, 6'h20, 3'h0, 12'h000);
    chk(skip_next, 1'b0, "skip out of range");
    ex(OP_ST_IND, 5'h03, 5'h03, 8'h00, 6'h00, 3'h0, 12'h000);
    stc(5'h10, 6'h12, 8'hF1);
    $display("io test done");
  endtask

  task automatic t_stack;
    logic [8:0] q [4];
    logic [8:0] p;
    p = program_counter;
    ex(OP_REL_JUMP, 5'h00, 5'h00, 8'h00, 6'h00, 3'h0, 12'hF00);
    chk(program_counter, p - 9'h100, "jump back wraps");
    for (int i = 0; i < 4; i++) begin
      q[i] = program_counter;
      ex(OP_REL_CALL, 5'h00, 5'h00, 8'h00, 6'h00, 3'h0, 12'h7FF);
      chk(program_counter, q[i] + 9'h1FF, "call target");
      chk(stack_fill, (i < 3) ? 9'(i + 1) : 9'h003, "fill");
    end
    for (int j = 3; j > 0; j--) begin
      ex(OP_SUB_EXIT, 5'h00, 5'h00, 8'h00, 6'h00, 3'h0, 12'h000);
      chk(program_counter, q[j] + 9'h001, "return");
      chk(stack_fill, 9'(j - 1), "fill after return");
    end
    $display("stack test done");
  endtask

  task automatic t_irq;
    logic [8:0] p;
    irq_pending = 1'b1;
    @(negedge ref_clk);
    chk(irq_taken, 1'b0, "masked interrupt");
    irq_pending = 1'b0;
    ldi(5'h14, 8'h80);
    ex(OP_IO_STORE, 5'h14, 5'h14, 8'h00, 6'h3F, 3'h0, 12'h000);
    chk(status_flags_register, 8'h80, "status write");
    p = program_counter;
    irq_pending = 1'b1;
    @(negedge ref_clk);
    chk(irq_taken, 1'b1, "interrupt taken");
    chk(program_counter, irq_vector, "vector");
    chk(status_flags_register[7], 1'b0, "enable cleared");
    chk(stack_fill, 9'h001, "pushed");
    irq_pending = 1'b0;
    @(negedge ref_clk);
    chk(irq_taken, 1'b0, "single pulse");
    ex(OP_INT_EXIT, 5'h00, 5'h00, 8'h00, 6'h00, 3'h0, 12'h000);
    chk(program_counter, p, "interrupt return");
    chk(status_flags_register[7], 1'b1, "enable restored");
    $display("interrupt test done");
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence and hang guard
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1; instr_valid = 1'b0; instr_op = OP_NOP; copy_dir_load = 1'b0;
    dest_sel = 5'h00; src_sel = 5'h00; imm_value = 8'h00; io_addr = 6'h00;
    bit_sel = 3'h0; rel_disp = 12'h000; irq_pending = 1'b0;
    irq_vector = 9'h002;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk(program_counter, 9'h000, "reset pc");
    chk(status_flags_register, 8'h00, "reset status");
    chk(stack_fill, 9'h000, "reset stack");
    t_alu;
    t_io;
    t_stack;
    t_irq;
    tally_and_finish;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("BAD %0t run did not end", $time);
    tally_and_finish;
  end
endmodule
